// >>> rtl/tac_defs.svh
// Register offsets, field positions and reset values of the timer channel.
// Assumes it is included by the package users; definitions only.
`ifndef TAC_DEFS_SVH
`define TAC_DEFS_SVH
`define TAC_A_CTRL    8'h00
`define TAC_A_CNT     8'h02
`define TAC_A_CNT_HI  8'h04
`define TAC_A_CNT_LO  8'h05
`define TAC_A_GRA     8'h06
`define TAC_A_GRB     8'h08
`define TAC_A_BUFA    8'h0A
`define TAC_A_STAT    8'h0C
`define TAC_F_RUN     0
`define TAC_F_SYNC    1
`define TAC_F_PWM     2
`define TAC_F_CLR_LO  3
`define TAC_F_CLR_HI  4
`define TAC_F_CAPA    5
`define TAC_F_CAPB    6
`define TAC_F_BUFA    7
`define TAC_F_CMB_LO  8
`define TAC_F_CMB_HI  9
`define TAC_F_CKS_LO  10
`define TAC_F_CKS_HI  11
`define TAC_S_FLAG_A  0
`define TAC_S_FLAG_B  1
`define TAC_S_WRAP    2
`define TAC_CTRL_RST  16'h0000
`define TAC_CNT_RST   16'h0000
`define TAC_GR_RST    16'hFFFF
`define TAC_CNT_MAX   16'hFFFF
`endif

// >>> rtl/tac_pkg.sv
// Types shared by the timer channel modules.
// Assumes nothing of its surroundings.
package tac_pkg;
  typedef enum logic [1:0] {
    TAC_ACC_NONE = 2'b00,
    TAC_ACC_RD   = 2'b01,
    TAC_ACC_WR   = 2'b10
  } tac_acc_t;
  typedef enum logic [1:0] {
    TAC_CMB_NORMAL = 2'b00,
    TAC_CMB_ALT    = 2'b01,
    TAC_CMB_COMP   = 2'b10,
    TAC_CMB_RSYNC  = 2'b11
  } tac_cmb_t;
endpackage

// >>> rtl/tac_bus_track.sv
// Tracks the state of each bus access to the timer registers.
// Assumes strobes on the same clock, one cycle long; the strobe cycle is
// the second state of an access and the following cycle its third.
`timescale 1ns/1ps
module tac_bus_track import tac_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  output tac_acc_t         t3_kind,
  output logic      [7:0]  t3_addr,
  output logic      [15:0] t3_wdata
);
  tac_acc_t    kind_nxt;
  logic [7:0]  addr_nxt;
  logic [15:0] wdata_nxt;

  always_comb begin
    kind_nxt  = wr ? TAC_ACC_WR : (rd ? TAC_ACC_RD : TAC_ACC_NONE);
    addr_nxt  = addr;
    wdata_nxt = wdata;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t3_kind  <= TAC_ACC_NONE;
      t3_addr  <= 8'h00;
      t3_wdata <= 16'h0000;
    end else begin
      t3_kind  <= kind_nxt;
      t3_addr  <= addr_nxt;
      t3_wdata <= wdata_nxt;
    end
  end
endmodule

// >>> rtl/tac_prescale.sv
// Counter input clock divider: a one-cycle increment pulse every
// 1, 2, 4 or 8 clocks while the channel runs.
// Assumes the run and select levels come from logic on the same clock.
`timescale 1ns/1ps
module tac_prescale #(
  parameter int DIV_W = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            inc
);
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [DIV_W-1:0] mask;
  logic             inc_nxt;

  always_comb begin
    mask    = DIV_W'((1 << sel) - 1);
    div_nxt = run ? div_r + DIV_W'(1) : '0;
    inc_nxt = run && ((div_r & mask) == mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= '0;
      inc   <= 1'b0;
    end else begin
      div_r <= div_nxt;
      inc   <= inc_nxt;
    end
  end
endmodule

// >>> rtl/tac_timer_ch0.sv
// Channel 0 of a 16-bit timer: counter, two general registers, buffer A,
// and the arbitration between bus accesses and timer events.
// Assumes a same-clock bus master; capture pins are asynchronous; the
// synchronized-channel ports connect to sibling channels on REF_CLK.
`timescale 1ns/1ps
`include "tac_defs.svh"
module tac_timer_ch0 import tac_pkg::*; (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  BUS_ADDR,
  input  wire logic [15:0] BUS_WDATA,
  input  wire logic        BUS_WR,
  input  wire logic        BUS_RD,
  output logic      [15:0] BUS_RDATA,
  input  wire logic        CAPT_A_PIN,
  input  wire logic        CAPT_B_PIN,
  input  wire logic        SYNC_LOAD_IN,
  input  wire logic [15:0] SYNC_VALUE_IN,
  input  wire logic        SYNC_CLEAR_IN,
  output logic             SYNC_LOAD_OUT,
  output logic      [15:0] SYNC_VALUE_OUT,
  output logic             SYNC_CLEAR_OUT,
  output logic             MATCH_A_OUT,
  output logic      [2:0]  STATUS_FLAGS,
  output logic      [1:0]  COMB_MODE_OUT
);
  tac_acc_t    t3_kind;
  logic [7:0]  t3_addr;
  logic [15:0] t3_wdata;
  logic        inc;
  logic [15:0] cnt_r, cnt_nxt, gra_r, gra_nxt, grb_r, grb_nxt;
  logic [15:0] bufa_r, bufa_nxt, ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
  logic [15:0] svo_r, svo_nxt, wr_val;
  logic [2:0]  flag_r, flag_nxt, sa_r, sa_nxt, sb_r, sb_nxt;
  logic        sload_r, sload_nxt, sclr_r, sclr_nxt, outa_r, outa_nxt;
  tac_cmb_t    cmb_r, cmb_nxt;
  logic        wr3, wr_cnt3, byte2, byte3, wr_gra3, wr_grb3, wr_bufa3;
  logic        wr_ctrl3, wr_stat3, pwm, sync_sel, inc_ok, edge_a, edge_b;
  logic        oc_a, oc_b, mat_a_raw, mat_b_raw, mat_a, mat_b, cap_a, cap_b;
  logic        clr_cap, clr_own, clr, wrap_set;
  logic [1:0]  clr_src;

  tac_bus_track u_track (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .wr       (BUS_WR),
    .rd       (BUS_RD),
    .addr     (BUS_ADDR),
    .wdata    (BUS_WDATA),
    .t3_kind  (t3_kind),
    .t3_addr  (t3_addr),
    .t3_wdata (t3_wdata)
  );

  tac_prescale #(.DIV_W(3)) u_pre (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .run (ctrl_r[`TAC_F_RUN]),
    .sel (ctrl_r[`TAC_F_CKS_HI:`TAC_F_CKS_LO]),
    .inc (inc)
  );

  // ----------------------------------------------------------------------
  // Access and event decode
  // ----------------------------------------------------------------------
  assign wr3      = (t3_kind == TAC_ACC_WR);
  assign byte3    = wr3 && (t3_addr == `TAC_A_CNT_HI || t3_addr == `TAC_A_CNT_LO);
  assign byte2    = BUS_WR && (BUS_ADDR == `TAC_A_CNT_HI || BUS_ADDR == `TAC_A_CNT_LO);
  assign wr_cnt3  = byte3 || (wr3 && t3_addr == `TAC_A_CNT);
  assign wr_gra3  = wr3 && t3_addr == `TAC_A_GRA;
  assign wr_grb3  = wr3 && t3_addr == `TAC_A_GRB;
  assign wr_bufa3 = wr3 && t3_addr == `TAC_A_BUFA;
  assign wr_ctrl3 = wr3 && t3_addr == `TAC_A_CTRL;
  assign wr_stat3 = wr3 && t3_addr == `TAC_A_STAT;
  assign pwm      = ctrl_r[`TAC_F_PWM];
  assign sync_sel = ctrl_r[`TAC_F_SYNC];
  assign clr_src  = {ctrl_r[`TAC_F_CLR_HI], ctrl_r[`TAC_F_CLR_LO]};
  assign edge_a   = sa_r[1] && !sa_r[2];
  assign edge_b   = sb_r[1] && !sb_r[2];
  // A byte write holds off counting in both its second and third state.
  assign inc_ok   = inc && !byte2 && !byte3;
  assign oc_a     = pwm || !ctrl_r[`TAC_F_CAPA];
  assign oc_b     = pwm || !ctrl_r[`TAC_F_CAPB];
  // Match fires on the increment that leaves the matching count.
  assign mat_a_raw = oc_a && inc_ok && cnt_r == gra_r && !wr_gra3;
  assign mat_b_raw = oc_b && inc_ok && cnt_r == grb_r && !wr_grb3;
  assign mat_a    = mat_a_raw && !(pwm && mat_b_raw);
  assign mat_b    = mat_b_raw && !(pwm && mat_a_raw);
  assign cap_a    = !pwm && ctrl_r[`TAC_F_CAPA] && edge_a;
  assign cap_b    = !pwm && ctrl_r[`TAC_F_CAPB] && edge_b;
  assign clr_cap  = (clr_src == 2'h1 && cap_a) || (clr_src == 2'h2 && cap_b);
  assign clr_own  = clr_cap || (clr_src == 2'h1 && mat_a) || (clr_src == 2'h2 && mat_b);
  assign clr      = clr_own || (clr_src == 2'h3 && sync_sel && SYNC_CLEAR_IN);
  assign wrap_set = inc_ok && cnt_r == `TAC_CNT_MAX && !clr_cap;

  always_comb begin
    wr_val = t3_wdata;
    if (t3_addr == `TAC_A_CNT_HI) begin
      wr_val = {t3_wdata[7:0], cnt_r[7:0]};
    end else if (t3_addr == `TAC_A_CNT_LO) begin
      wr_val = {cnt_r[15:8], t3_wdata[7:0]};
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = `TAC_CNT_RST;
    end else if (sync_sel && SYNC_LOAD_IN) begin
      cnt_nxt = SYNC_VALUE_IN;
    end else if (wr_cnt3) begin
      cnt_nxt = wr_val;
    end else if (inc_ok) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    gra_nxt = gra_r;
    if (cap_a) begin
      gra_nxt = cnt_r;
    end else if (wr_gra3) begin
      gra_nxt = t3_wdata;
    end else if (mat_a && ctrl_r[`TAC_F_BUFA]) begin
      gra_nxt = bufa_r;
    end
    grb_nxt = cap_b ? cnt_r : (wr_grb3 ? t3_wdata : grb_r);
    bufa_nxt = bufa_r;
    if (cap_a && ctrl_r[`TAC_F_BUFA]) begin
      bufa_nxt = gra_r;
    end else if (wr_bufa3) begin
      bufa_nxt = t3_wdata;
    end
    ctrl_nxt = wr_ctrl3 ? t3_wdata : ctrl_r;
    // Writing zero clears a flag; an event in the same cycle wins.
    flag_nxt = (wr_stat3 ? (flag_r & t3_wdata[2:0]) : flag_r)
             | {wrap_set, mat_b || cap_b, mat_a || cap_a};
    // Only the complementary and reset-synchronized codes leave normal mode.
    cmb_nxt = tac_cmb_t'(ctrl_r[`TAC_F_CMB_HI:`TAC_F_CMB_LO]);
    if (cmb_nxt == TAC_CMB_ALT) begin
      cmb_nxt = TAC_CMB_NORMAL;
    end
    sload_nxt = sync_sel && wr_cnt3 && !clr;
    svo_nxt   = wr_val;
    sclr_nxt  = sync_sel && clr_own;
    outa_nxt  = outa_r ^ mat_a;
    sa_nxt    = {sa_r[1], sa_r[0], CAPT_A_PIN};
    sb_nxt    = {sb_r[1], sb_r[0], CAPT_B_PIN};
    // Read data are taken in the strobe cycle, before any third-state capture.
    rdata_nxt = 16'h0000;
    if (BUS_RD) begin
      case (BUS_ADDR)
        `TAC_A_CTRL:   rdata_nxt = ctrl_r;
        `TAC_A_CNT:    rdata_nxt = cnt_r;
        `TAC_A_CNT_HI: rdata_nxt = {8'h00, cnt_r[15:8]};
        `TAC_A_CNT_LO: rdata_nxt = {8'h00, cnt_r[7:0]};
        `TAC_A_GRA:    rdata_nxt = gra_r;
        `TAC_A_GRB:    rdata_nxt = grb_r;
        `TAC_A_BUFA:   rdata_nxt = bufa_r;
        `TAC_A_STAT:   rdata_nxt = {13'h0000, flag_r};
        default:       rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cnt_r   <= `TAC_CNT_RST;
      gra_r   <= `TAC_GR_RST;
      grb_r   <= `TAC_GR_RST;
      bufa_r  <= `TAC_GR_RST;
      ctrl_r  <= `TAC_CTRL_RST;
      flag_r  <= 3'h0;
      cmb_r   <= TAC_CMB_NORMAL;
      sload_r <= 1'b0;
      svo_r   <= 16'h0000;
      sclr_r  <= 1'b0;
      outa_r  <= 1'b0;
      sa_r    <= 3'h0;
      sb_r    <= 3'h0;
      rdata_r <= 16'h0000;
    end else begin
      cnt_r   <= cnt_nxt;
      gra_r   <= gra_nxt;
      grb_r   <= grb_nxt;
      bufa_r  <= bufa_nxt;
      ctrl_r  <= ctrl_nxt;
      flag_r  <= flag_nxt;
      cmb_r   <= cmb_nxt;
      sload_r <= sload_nxt;
      svo_r   <= svo_nxt;
      sclr_r  <= sclr_nxt;
      outa_r  <= outa_nxt;
      sa_r    <= sa_nxt;
      sb_r    <= sb_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign BUS_RDATA      = rdata_r;
  assign SYNC_LOAD_OUT  = sload_r;
  assign SYNC_VALUE_OUT = svo_r;
  assign SYNC_CLEAR_OUT = sclr_r;
  assign MATCH_A_OUT    = outa_r;
  assign STATUS_FLAGS   = flag_r;
  assign COMB_MODE_OUT  = cmb_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_word_wr;
    BUS_WR && BUS_ADDR == `TAC_A_CNT ##1 inc && !clr && !(sync_sel && SYNC_LOAD_IN);
  endsequence
  sequence s_byte_inc;
    byte2 && inc ##1 !clr && !(sync_sel && SYNC_LOAD_IN);
  endsequence
  sequence s_gra_read_cap;
    BUS_RD && BUS_ADDR == `TAC_A_GRA ##1 cap_a;
  endsequence

  AST_WORD_WR_WINS: assert property (
    s_word_wr |=> cnt_r == $past(t3_wdata)) else $error("word write lost to increment");
  AST_BYTE_NO_INC: assert property (
    s_byte_inc |=> cnt_r == $past(wr_val)) else $error("byte write let counter increment");
  AST_GR_WR_NO_MATCH: assert property (
    wr_gra3 |-> !mat_a ##1 outa_r == $past(outa_r)) else $error("match during register write");
  AST_WRITE_WRAP_FLAG: assert property (
    wr_cnt3 && inc_ok && cnt_r == `TAC_CNT_MAX && !clr && !wr_stat3 && !SYNC_LOAD_IN
      |=> flag_r[`TAC_S_WRAP] && cnt_r == $past(wr_val)) else $error("wrap flag lost on write");
  AST_READ_BEFORE_CAP: assert property (
    s_gra_read_cap |-> BUS_RDATA == $past(gra_r)) else $error("read saw captured value");
  AST_CAP_CLEAR: assert property (
    cap_a && clr_src == 2'h1 && inc |=> cnt_r == 16'h0000 && gra_r == $past(cnt_r))
    else $error("capture clear did not win");
  AST_CAP_BEATS_WR: assert property (
    wr_gra3 && cap_a |=> gra_r == $past(cnt_r)) else $error("bus write beat capture");
  AST_MATCH_PERIOD: assert property (
    mat_a && clr_src == 2'h1 |-> cnt_r == gra_r ##1 cnt_r == 16'h0000)
    else $error("match clear at wrong count");
  AST_BUF_CAPTURE: assert property (
    wr_bufa3 && cap_a && ctrl_r[`TAC_F_BUFA] |=> bufa_r == $past(gra_r))
    else $error("buffer write beat capture transfer");
  AST_SYNC_LOAD: assert property (
    sync_sel && wr_cnt3 && !clr && !SYNC_LOAD_IN |=> SYNC_LOAD_OUT && SYNC_VALUE_OUT == cnt_r)
    else $error("synchronized load missing");
  AST_CAP_NO_WRAP: assert property (
    clr_cap && cnt_r == `TAC_CNT_MAX && !flag_r[`TAC_S_WRAP]
      |=> !flag_r[`TAC_S_WRAP]) else $error("wrap on capture clear");
  AST_PWM_NO_CAP: assert property (
    pwm |-> !cap_a && !cap_b && !(mat_a && mat_b)) else $error("capture or double match in pwm");
  AST_CMB_NORMAL: assert property (
    wr_ctrl3 && t3_wdata[`TAC_F_CMB_HI] == 1'b0 |=> ##1 COMB_MODE_OUT == TAC_CMB_NORMAL)
    else $error("normal mode not restored");
  AST_WRAP_ROLL: assert property (
    inc_ok && cnt_r == `TAC_CNT_MAX && !clr_cap |=> flag_r[`TAC_S_WRAP])
    else $error("wrap flag not set on roll over");
  AST_BYTE_T2_HOLD: assert property (
    byte2 && inc && !wr_cnt3 && !clr && !(sync_sel && SYNC_LOAD_IN) |=> cnt_r == $past(cnt_r))
    else $error("counter moved in byte write second state");
  AST_CAP_B_LOAD: assert property (
    cap_b |=> grb_r == $past(cnt_r) && flag_r[`TAC_S_FLAG_B])
    else $error("capture b did not load register");
  AST_CAP_A_NO_MATCH: assert property (
    ctrl_r[`TAC_F_CAPA] && !pwm |-> !mat_a)
    else $error("compare match on capture register");
  AST_SYNC_CLEAR_IN: assert property (
    clr_src == 2'h3 && sync_sel && SYNC_CLEAR_IN |=> cnt_r == `TAC_CNT_RST)
    else $error("synchronized clear ignored");
  AST_SYNC_CLEAR_OUT: assert property (
    sync_sel && clr_own |=> SYNC_CLEAR_OUT)
    else $error("clear not passed to synchronized channels");
  AST_RDATA_ONE_CYCLE: assert property (
    !BUS_RD |=> BUS_RDATA == 16'h0000)
    else $error("read data stood beyond one cycle");
endmodule

// >>> testbench/tac_cpu_model.sv
// Bus master model that reaches the timer channel registers.
// Assumes each task is called just after a rising edge of clk.
`timescale 1ns/1ps
`include "tac_defs.svh"
module tac_cpu_model (
  input  wire logic        clk,
  output logic      [7:0]  bus_addr,
  output logic      [15:0] bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd,
  input  wire logic [15:0] bus_rdata
);
  initial begin
    bus_addr  = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end

  // One strobe cycle, then an idle cycle so that two calls never meet.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    @(posedge clk);
    d = bus_rdata;
  endtask

  // Mode bits change with this channel's counter stopped and through normal mode.
  task automatic set_cmb(input logic [1:0] m);
    wr(`TAC_A_CTRL, 16'h0000);
    wr(`TAC_A_CTRL, {6'h00, m, 8'h00});
  endtask
endmodule

// >>> testbench/tb_timer_access_contention_modes.sv
// Self-checking bench for channel 0 of the timer.
// Assumes the bus master model drives the register port.
`timescale 1ns/1ps
`include "tac_defs.svh"
module tb_timer_access_contention_modes;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        pin_a;
  logic        pin_b;
  logic        sclr;
  logic        sclr_out;
  logic        sload_in;
  logic [15:0] svalue_in;
  logic        sload_out;
  logic [15:0] svalue_out;
  logic        match_a;
  logic [2:0]  flags;
  logic [1:0]  cmb;
  logic [15:0] d;
  int          n;
  int          num_errors;
  int          checks;
  int          sclr_cnt;
  logic [15:0] cap_ctrl [4] = '{16'h0008, 16'h0028, 16'h002C, 16'h0040};
  logic [15:0] cap_exp  [4] = '{16'h0003, 16'h0051, 16'h0051, 16'h0053};
  logic [1:0]  cmb_exp  [4] = '{2'b00, 2'b00, 2'b10, 2'b11};

  tac_cpu_model cpu_u (.clk(clk), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr),
                       .bus_rd(rd), .bus_rdata(rdata));
  tac_timer_ch0 dut_u (.REF_CLK(clk), .SYS_RST(rst), .BUS_ADDR(addr), .BUS_WDATA(wdata),
                       .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata), .CAPT_A_PIN(pin_a),
                       .CAPT_B_PIN(pin_b), .SYNC_LOAD_IN(sload_in), .SYNC_VALUE_IN(svalue_in),
                       .SYNC_CLEAR_IN(sclr), .SYNC_LOAD_OUT(sload_out),
                       .SYNC_VALUE_OUT(svalue_out), .SYNC_CLEAR_OUT(sclr_out),
                       .MATCH_A_OUT(match_a),
                       .STATUS_FLAGS(flags), .COMB_MODE_OUT(cmb));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts cycles in which the clear is passed to the other channels.
  always @(posedge clk) begin
    if (sclr_out === 1'b1) begin
      sclr_cnt <= sclr_cnt + 1;
    end
  end

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Rising edge on one capture pin, held past the synchronizer delay.
  task automatic pulse(input logic b);
    pin_a <= ~b;
    pin_b <= b;
    repeat (6) @(posedge clk);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Counts clocks between two toggles of the compare output.
  task automatic gap(output int g);
    logic m;
    for (int k = 0; k < 2; k++) begin
      m = match_a;
      g = 0;
      while (match_a === m) begin
        @(posedge clk);
        g++;
        if (g > 64) begin
          num_errors++;
          stop_test();
        end
      end
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    num_errors = 0;
    checks = 0;
    rst = 1'b1;
    pin_a = 1'b0;
    pin_b = 1'b0;
    sclr = 1'b0;
    sload_in = 1'b0;
    svalue_in = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    cpu_u.rd(`TAC_A_CNT, d);
    chk("count reset", 16'h0000, d);
    cpu_u.rd(`TAC_A_GRA, d);
    chk("gra reset", 16'hFFFF, d);
    cpu_u.rd(8'h0E, d);
    chk("unmapped", 16'h0000, d);
    $display("test reset done");
    // Counter runs one step per clock through the contention checks.
    cpu_u.wr(`TAC_A_CTRL, 16'h0001);
    cpu_u.wr(`TAC_A_CNT, 16'h1234);
    cpu_u.rd(`TAC_A_CNT, d);
    chk("word write", 16'h1234, d);
    cpu_u.wr(`TAC_A_CNT, 16'h1200);
    cpu_u.wr(`TAC_A_CNT_HI, 16'h0034);
    cpu_u.rd(`TAC_A_CNT, d);
    chk("byte write", 16'h3400, d);
    cpu_u.wr(`TAC_A_CNT, 16'hFFFE);
    cpu_u.wr(`TAC_A_CNT, 16'h0010);
    cpu_u.rd(`TAC_A_CNT, d);
    chk("write at wrap", 16'h0010, d);
    chk("wrap flag", 16'h0004, {13'h0000, flags[2], 2'b00});
    cpu_u.wr(`TAC_A_STAT, 16'h0000);
    cpu_u.wr(`TAC_A_CNT, 16'hFFF0);
    chk("flag cleared", 16'h0000, {13'h0000, flags[2], 2'b00});
    repeat (20) @(posedge clk);
    chk("roll over flag", 16'h0004, {13'h0000, flags[2], 2'b00});
    $display("test contention done");
    cpu_u.wr(`TAC_A_CTRL, 16'h0000);
    cpu_u.wr(`TAC_A_GRA, 16'h0003);
    cpu_u.wr(`TAC_A_CNT, 16'h0000);
    cpu_u.wr(`TAC_A_CTRL, 16'h0009);
    gap(n);
    chk("match period", 16'h0004, 16'(n));
    cpu_u.wr(`TAC_A_CTRL, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      cpu_u.wr(`TAC_A_CNT, 16'h0050 + 16'(i));
      cpu_u.wr(`TAC_A_CTRL, cap_ctrl[i]);
      pulse(i == 3);
      cpu_u.rd(i == 3 ? `TAC_A_GRB : `TAC_A_GRA, d);
      chk("capture", cap_exp[i], d);
    end
    cpu_u.wr(`TAC_A_STAT, 16'h0000);
    // The capture lands with the increment that would leave the all-ones count.
    cpu_u.wr(`TAC_A_CNT, 16'hFFFE);
    cpu_u.wr(`TAC_A_CTRL, 16'h0029);
    pulse(1'b0);
    cpu_u.rd(`TAC_A_GRA, d);
    chk("capture at max", 16'hFFFF, d);
    cpu_u.rd(`TAC_A_CNT, d);
    chk("capture clear", 16'h0007, d);
    chk("no wrap", 16'h0000, {13'h0000, flags[2], 2'b00});
    $display("test modes done");
    cpu_u.wr(`TAC_A_CTRL, 16'h0002);
    cpu_u.wr(`TAC_A_CNT, 16'h1100);
    cpu_u.wr(`TAC_A_CNT_LO, 16'h0077);
    n = 0;
    while (sload_out !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("sync load", 16'h0001, {15'h0000, sload_out});
    chk("sync value", 16'h1177, svalue_out);
    sload_in <= 1'b1;
    svalue_in <= 16'hABCD;
    @(posedge clk);
    sload_in <= 1'b0;
    cpu_u.rd(`TAC_A_CNT, d);
    chk("sync preset", 16'hABCD, d);
    cpu_u.wr(`TAC_A_CTRL, 16'h001A);
    sclr <= 1'b1;
    @(posedge clk);
    sclr <= 1'b0;
    repeat (2) @(posedge clk);
    cpu_u.rd(`TAC_A_CNT, d);
    chk("sync clear", 16'h0000, d);
    cpu_u.wr(`TAC_A_CTRL, 16'h002A);
    pulse(1'b0);
    chk("sync clear out", 16'h0001, 16'(sclr_cnt));
    for (int i = 0; i < 4; i++) begin
      cpu_u.set_cmb(2'(i));
      repeat (2) @(posedge clk);
      chk("comb mode", {14'h0000, cmb_exp[i]}, {14'h0000, cmb});
    end
    $display("test sync and combination done");
    stop_test();
  end
endmodule
